// *** test_tw_ctrl.sv ***
/*
  Self-checking bench for tw_ctrl: APB tasks, slave address table
  through an external bus model, master sequence and clock stretch.
  Assumes tw_bus_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module test_tw_ctrl;
  import tw_pkg::*;
  typedef struct {
    logic [15:0] ctl;
    logic [9:0] msk;
    logic [7:0] adr;
    logic idl;
    logic ack;
    logic gc;
  } tw_row_s;
  logic clk, nrst, psel, stop_go, pwr, idle, lerr, ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, scl_oe, sda_oe, own, gc, m_scl, m_sda, sp, dp;
  logic scl, sda;
  int n_fail, checked, gcn, g0, cyc, t_sda, t_scl, gap;
  tw_row_s tb [15];
  assign scl = m_scl & ~scl_oe;
  assign sda = m_sda & ~sda_oe;
  tw_ctrl dut (.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(stop_go),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SCL_I(scl), .SCL_O(),
    .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe),
    .IDLE_I(idle), .PIN_OWN_O(own), .SLEW_OFF_O(), .SMB_LVL_O(),
    .GC_EVT_O(gc));
  tw_bus_model bm (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_o(m_scl),
    .sda_o(m_sda));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    gcn <= gcn + int'(gc === 1'b1);
    if (sda_oe && !dp) t_sda <= cyc;
    if (scl_oe && !sp) begin
      t_scl <= cyc;
      gap <= cyc - t_scl;
    end
    dp <= sda_oe;
    sp <= scl_oe;
  end

  task automatic chk(input string nm, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    stop_go <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    stop_go <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input string nm, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int i;
    i = 0;
    do begin
      bus(1'b0, a, 32'h0);
      i++;
    end while (q[b] !== v && i < 300);
    chk("poll", 32'(v), 32'(q[b]));
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {nrst, psel, stop_go, pwr, idle, paddr, pwdata} = '0;
    {sp, dp, cyc, gcn, t_sda, t_scl, gap, n_fail, checked} = '0;
    tb = '{'{16'h9000, 10'h000, 8'hA4, 0, 0, 0},
      '{16'h9000, 10'h000, 8'hA6, 0, 1, 0},
      '{16'h9000, 10'h001, 8'hA6, 0, 0, 0},
      '{16'h9000, 10'h07F, 8'h02, 0, 1, 0},
      '{16'h9000, 10'h07F, 8'h08, 0, 1, 0},
      '{16'h9000, 10'h07F, 8'hF8, 0, 1, 0},
      '{16'h9000, 10'h07F, 8'h01, 0, 1, 0},
      '{16'h9000, 10'h07F, 8'hF6, 0, 1, 0},
      '{16'h9400, 10'h000, 8'hF6, 0, 0, 0},
      '{16'h9000, 10'h000, 8'h00, 0, 1, 0},
      '{16'h9080, 10'h000, 8'h00, 0, 0, 1},
      '{16'h9800, 10'h000, 8'h20, 0, 0, 0},
      '{16'h9000, 10'h001, 8'hA6, 0, 0, 0},
      '{16'hB000, 10'h000, 8'hA4, 1, 1, 0},
      '{16'h1000, 10'h000, 8'hA4, 0, 1, 0}};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(OFF_CTRL, "ctrl reset", 32'h1000);
    rc(OFF_MASK, "mask reset", 32'h0);
    wr(8'h1C, 32'h1);
    chk("slverr", 32'h1, 32'(lerr));
    rc(8'h1C, "unmapped", 32'h0);
    wr(OFF_CTRL, 32'h0300);
    rc(OFF_CTRL, "rel set only", 32'h1300);
    wr(OFF_CTRL, 32'h0040);
    rc(OFF_CTRL, "rel kept", 32'h1040);
    wr(OFF_CTRL, 32'h0040);
    rc(OFF_CTRL, "rel cleared", 32'h0040);
    wr(OFF_OWN, 32'h352);
    wr(OFF_BAUD, 32'h7);
    foreach (tb[i]) begin
      wr(OFF_MASK, 32'(tb[i].msk));
      wr(OFF_CTRL, 32'(tb[i].ctl));
      idle <= tb[i].idl;
      g0 = gcn;
      bm.frame(tb[i].adr, ack);
      chk("ack", 32'(tb[i].ack), 32'(ack));
      chk("call event", 32'(tb[i].gc), 32'(gcn - g0));
      chk("pin own", 32'(tb[i].ctl[15]), 32'(own));
      idle <= 1'b0;
    end
    wr(OFF_CTRL, 32'h9001);
    poll(OFF_CTRL, C_START, 1'b0);
    chk("half period", 32'd5, 32'(t_scl - t_sda));
    wr(OFF_TX, 32'h30);
    poll(OFF_STAT, S_TXFULL, 1'b0);
    chk("bit period", 32'd10, 32'(gap));
    rc(OFF_STAT, "nack seen", 32'h8008);
    wr(OFF_CTRL, 32'h9002);
    poll(OFF_CTRL, C_RS, 1'b0);
    wr(OFF_CTRL, 32'h9008);
    poll(OFF_CTRL, C_RXGO, 1'b0);
    rc(OFF_RX, "rx byte", 32'hFF);
    wr(OFF_CTRL, 32'h9030);
    poll(OFF_CTRL, C_ACKGO, 1'b0);
    wr(OFF_CTRL, 32'h9004);
    poll(OFF_CTRL, C_STOP, 1'b0);
    chk("lines free", 32'h0, 32'({sda_oe, scl_oe}));
    wr(OFF_TX, 32'hFF);
    fork
      bm.frame(8'hA5, ack);
    join_none
    poll(OFF_CTRL, C_REL, 1'b0);
    repeat (20) @(posedge clk);
    chk("stretch", 32'h0, 32'(scl));
    wr(OFF_CTRL, 32'h9000);
    wait fork;
    chk("read ack", 32'h0, 32'(ack));
    final_report();
  end
  // The longest path is a few thousand cycles; this is a generous cap.
  initial begin
    #2400000;
    n_fail++;
    final_report();
  end
endmodule

`default_nettype wire

// *** tw_baud.sv ***
/*
  Serial clock phase timer for the bus master. One bit period lasts
  reload + 1 + the fixed pin delay cycles, split into a low and a
  high phase; tick_o pulses at every phase boundary.
  Assumes hold_i is raised while another party keeps the clock low.
*/
`timescale 1ns/1ps
`default_nettype none

module tw_baud
  import tw_pkg::*;
#(
  parameter int unsigned BRG_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Control
  input wire logic run_i,
  input wire logic hold_i,
  input wire logic [BRG_W-1:0] reload_i,
  // Phase boundary
  output logic tick_o
);

  localparam int unsigned CW = BRG_W + 1;

  initial begin
    if (BRG_W < 2 || BRG_W > 16) begin
      $error("tw_baud: BRG_W must lie between 2 and 16");
    end
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic hi;
  } tw_baud_s;

  tw_baud_s q, d;
  logic [CW-1:0] total, hi_len, lo_len;

  always_comb begin
    total = CW'(reload_i) + CW'(1) + CW'(PIN_DLY_CYC); // R2
    hi_len = total >> 1;
    lo_len = total - hi_len;
    d = q;
    tick_o = 1'b0;
    if (!run_i) begin
      d.cnt = lo_len - CW'(1);
      d.hi = 1'b0;
    end else if (q.cnt != '0) begin
      // Counting overlaps the line's sync lag; only a stretch waits.
      d.cnt = q.cnt - CW'(1);
    end else if (!hold_i) begin // R21
      tick_o = 1'b1;
      d.hi = ~q.hi;
      d.cnt = q.hi ? lo_len - CW'(1) : hi_len - CW'(1); // R21
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// *** tw_bus_model.sv ***
/*
  External two-wire master that addresses the block as a slave.
  Assumes pulled-up lines resolved outside; a 0 output pulls low.
*/
`timescale 1ns/1ps
`default_nettype none

module tw_bus_model (
  // Clock
  input wire logic clk_i,
  // Resolved lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Own drive
  output logic scl_o,
  output logic sda_o
);
  localparam int HALF = 12;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // A slave may keep the clock low; the wait is bounded.
  task automatic rise();
    int i;
    i = 0;
    scl_o <= 1'b1;
    while (scl_i !== 1'b1 && i < 4000) begin
      @(posedge clk_i);
      i++;
    end
    hw(HALF);
  endtask
  // Start, one byte MSB first, ack clock, stop.
  task automatic frame(input logic [7:0] b, output logic ack);
    logic [8:0] w;
    w = {b, 1'b1};
    sda_o <= 1'b0;
    hw(HALF);
    for (int k = 8; k >= 0; k--) begin
      scl_o <= 1'b0;
      hw(4);
      sda_o <= w[k];
      hw(HALF);
      rise();
    end
    ack = sda_i;
    scl_o <= 1'b0;
    hw(4);
    sda_o <= 1'b0;
    hw(HALF);
    rise();
    sda_o <= 1'b1;
    hw(HALF);
  endtask
endmodule

`default_nettype wire

// *** tw_ctrl.sv ***
/*
  Two-wire bus controller: master sequencer, addressed slave with
  masking and clock stretching, and an APB register file.
  Assumes open-drain pins resolved outside (drive low when enabled),
  a 25 MHz clock, and IDLE_I from the same clock domain.
*/
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Software sequences start, write address, data, restart, read, ack, stop.
// R2: Bit rate equals clock over reload plus one plus clock/10 MHz.
// R3: Set mask bits make that incoming address bit a don't-care.
// R4: Software clears accept-all mode before masking takes effect.
// R5: Reserved addresses never match, whatever the mask.
// R6: General call with write is acknowledged only if enabled.
// R7: Pattern 11110xx matches only as ten-bit upper byte.
// R8: Module enable owns both pins; clear returns them to port control.
// R9: Halt-when-idle stops the module while the chip idles.
// R10: Slave holds clock low while clock release is zero; resets to one.
// R11: Stretch on: software writes release freely; hardware clears at tx/rx.
// R12: Stretch off: software only sets release; hardware clears at tx start.
// R13: Accept-all mode acknowledges every address.
// R14: Wide-address select makes own address ten bits, else seven.
// R15: Slew-limit-off and bus-management threshold controls, both reset zero.
// R16: General call with enable raises an event output.
// R17: Stretch enable permits software and receive clock stretching.
// R18: Start, restart, stop controls generate condition, cleared when done.
// R19: Master receive control takes one byte, cleared after eighth bit.
// R20: Ack sequence sends stored ack value, then clears its control.
// R21: Baud counter reloads each phase, holds while clock is stretched.
module tw_ctrl
  import tw_pkg::*;
#(
  parameter int unsigned BRG_W = 16
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Two-wire pins, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // System
  input wire logic IDLE_I,
  output logic PIN_OWN_O,
  output logic SLEW_OFF_O,
  output logic SMB_LVL_O,
  output logic GC_EVT_O
);

  import tw_pkg::*;

  initial begin
    if (BRG_W < 2 || BRG_W > 16) begin
      $error("tw_ctrl: BRG_W must lie between 2 and 16");
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [BRG_W-1:0] baud;
    logic [9:0] mask;
    logic [9:0] own;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [15:0] stat;
    logic [31:0] prdata;
    tw_mst_e mst;
    logic [3:0] mcnt;
    logic [1:0] mstep;
    logic mhi;
    logic [7:0] msh;
    logic mscl;
    logic msda;
    logic mown;
    tw_slv_e sst;
    tw_slv_e snext;
    logic [3:0] scnt;
    logic [7:0] ssh;
    logic sack;
    logic sdrv;
    logic shold;
    logic scl_p;
    logic sda_p;
    logic gc_evt;
  } tw_ctrl_s;

  tw_ctrl_s q, d;
  logic [1:0] lines;
  logic scl_f, sda_f, tick, run;

  tw_sync #(
    .W(2)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_ni(NRST_I),
    .pin_i({SCL_I, SDA_I}),
    .lvl_o(lines)
  );

  assign scl_f = lines[1];
  assign sda_f = lines[0];

  // Halt-when-idle returns both engines to idle but keeps registers.
  assign run = q.ctrl[C_ON] && !(q.ctrl[C_HALT] && IDLE_I); // R8 R9

  // Master clock synchronisation: wait while the line is held low.
  tw_baud #(
    .BRG_W(BRG_W)
  ) u_baud (
    .clk_i(CLK_I),
    .rst_ni(NRST_I),
    .run_i(run && q.mst != M_IDLE),
    .hold_i(!q.mscl && !scl_f), // R21
    .reload_i(q.baud),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic setup, wr, rd, hit;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] byte_in;
  logic [6:0] a7;
  logic rsvd, up_hit, take, landed;

  always_comb begin
    d = q;
    setup = PSEL_I && !PENABLE_I;
    wr = PSEL_I && PENABLE_I && PWRITE_I;
    rd = PSEL_I && PENABLE_I && !PWRITE_I;
    hit = PADDR_I == OFF_CTRL || PADDR_I == OFF_STAT ||
          PADDR_I == OFF_BAUD || PADDR_I == OFF_MASK ||
          PADDR_I == OFF_OWN || PADDR_I == OFF_TX || PADDR_I == OFF_RX;
    scl_rise = scl_f && !q.scl_p;
    scl_fall = !scl_f && q.scl_p;
    bus_start = q.sda_p && !sda_f && scl_f && q.scl_p;
    bus_stop = !q.sda_p && sda_f && scl_f && q.scl_p;
    byte_in = {q.ssh[6:0], sda_f};
    a7 = byte_in[7:1];
    rsvd = a7[6:3] == 4'h0 || a7[6:3] == 4'hF; // R5 R7
    up_hit = ((byte_in[2:1] ^ q.own[9:8]) & ~q.mask[9:8]) == 2'b00; // R3
    take = 1'b0;
    landed = 1'b0;
    d.scl_p = scl_f;
    d.sda_p = sda_f;
    d.gc_evt = 1'b0;

    // -------------------------------------------------------------
    // Master sequencer
    // -------------------------------------------------------------
    unique case (q.mst)
      M_IDLE: begin
        d.mstep = 2'd0;
        d.mcnt = 4'd0;
        d.mhi = 1'b0;
        if (q.ctrl[C_START] && !q.mown) begin
          d.mst = M_START;
        end else if (q.ctrl[C_RS]) begin
          d.mst = M_RSTART;
        end else if (q.ctrl[C_STOP]) begin
          d.mst = M_STOP;
        end else if (q.ctrl[C_RXGO]) begin
          d.mst = M_RX;
          d.msda = 1'b0;
        end else if (q.ctrl[C_ACKGO]) begin
          d.mst = M_ACK;
          d.msda = ~q.ctrl[C_ACKV]; // R20
        end else if (q.mown && q.stat[S_TXFULL]) begin
          d.mst = M_TX;
          d.msh = q.txd;
          d.msda = ~q.txd[7];
          d.stat[S_TRST] = 1'b1;
        end
      end
      M_START: begin
        if (tick) begin
          d.mstep = q.mstep + 2'd1;
          if (q.mstep == 2'd0) begin
            d.msda = 1'b1;
          end else begin
            d.mscl = 1'b1;
            d.mown = 1'b1;
            d.ctrl[C_START] = 1'b0; // R18
            d.mst = M_IDLE;
          end
        end
      end
      M_RSTART: begin
        if (tick) begin
          d.mstep = q.mstep + 2'd1;
          unique case (q.mstep)
            2'd0: d.msda = 1'b0;
            2'd1: d.mscl = 1'b0;
            2'd2: d.msda = 1'b1;
            2'd3: begin
              d.mscl = 1'b1;
              d.ctrl[C_RS] = 1'b0; // R18
              d.mst = M_IDLE;
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          d.mstep = q.mstep + 2'd1;
          if (q.mstep == 2'd0) begin
            d.msda = 1'b1;
          end else if (q.mstep == 2'd1) begin
            d.mscl = 1'b0;
          end else begin
            d.msda = 1'b0;
            d.mown = 1'b0;
            d.ctrl[C_STOP] = 1'b0; // R18
            d.mst = M_IDLE;
          end
        end
      end
      M_TX, M_RX, M_ACK: begin
        if (tick && !q.mhi) begin
          d.mscl = 1'b0;
          d.mhi = 1'b1;
        end else if (tick) begin
          d.mscl = 1'b1;
          d.mhi = 1'b0;
          d.mcnt = q.mcnt + 4'd1;
          if (q.mst == M_TX) begin
            d.msh = {q.msh[6:0], 1'b0};
            d.msda = (q.mcnt < 4'd7) ? ~q.msh[6] : 1'b0;
            if (q.mcnt == 4'd8) begin
              d.stat[S_ACKST] = sda_f;
              d.stat[S_TRST] = 1'b0;
              d.stat[S_TXFULL] = 1'b0;
              d.msda = 1'b0;
              d.mst = M_IDLE;
            end
          end else if (q.mst == M_RX) begin
            d.msh = {q.msh[6:0], sda_f};
            if (q.mcnt == 4'd7) begin
              d.rxd = {q.msh[6:0], sda_f};
              d.stat[S_RXFULL] = 1'b1;
              landed = 1'b1;
              d.ctrl[C_RXGO] = 1'b0; // R19
              d.mst = M_IDLE;
            end
          end else begin
            d.msda = 1'b0;
            d.ctrl[C_ACKGO] = 1'b0; // R20
            d.mst = M_IDLE;
          end
        end
      end
      default: d.mst = M_IDLE;
    endcase

    // -------------------------------------------------------------
    // Slave engine
    // -------------------------------------------------------------
    if (bus_start) begin
      d.sst = SL_ADDR;
      d.scnt = 4'd0;
      d.stat[S_STARTD] = 1'b1;
      d.stat[S_STOPD] = 1'b0;
    end else if (bus_stop) begin
      d.sst = SL_IDLE;
      d.stat[S_STOPD] = 1'b1;
      d.stat[S_STARTD] = 1'b0;
      d.stat[S_GCST] = 1'b0;
      d.stat[S_ADD10] = 1'b0;
    end else if (q.sst != SL_IDLE && scl_rise) begin
      d.scnt = q.scnt + 4'd1;
      d.ssh = byte_in;
      if (q.scnt == 4'd7 && q.sst != SL_TX) begin
        d.sack = 1'b0;
        d.snext = SL_IDLE;
        unique case (q.sst)
          SL_ADDR: begin
            if (q.ctrl[C_ALL]) begin // R13
              take = 1'b1;
              d.snext = byte_in[0] ? SL_TX : SL_RX;
            end else if (byte_in == 8'h00) begin
              take = q.ctrl[C_GC]; // R6
              d.stat[S_GCST] = take;
              d.gc_evt = take; // R16
              d.snext = SL_RX;
            end else if (q.ctrl[C_WIDE] && a7[6:2] == 5'b11110) begin
              take = up_hit && (!byte_in[0] || q.stat[S_ADD10]); // R7 R14
              d.snext = byte_in[0] ? SL_TX : SL_ADDR2;
            end else if (!q.ctrl[C_WIDE] && !rsvd) begin // R5 R14
              take = ((a7 ^ q.own[6:0]) & ~q.mask[6:0]) == 7'h00; // R3
              d.snext = byte_in[0] ? SL_TX : SL_RX;
            end
            if (take) begin
              d.stat[S_RDIR] = byte_in[0];
              d.stat[S_DATA] = 1'b0;
            end
          end
          SL_ADDR2: begin
            take = ((byte_in ^ q.own[7:0]) & ~q.mask[7:0]) == 8'h00; // R3
            d.stat[S_ADD10] = take;
            d.snext = SL_RX;
          end
          default: begin
            take = !q.stat[S_RXFULL];
            d.rxd = byte_in;
            d.stat[S_RXFULL] = 1'b1;
            landed = 1'b1;
            d.stat[S_DATA] = 1'b1;
            d.snext = SL_RX;
            if (q.ctrl[C_STR]) begin
              d.ctrl[C_REL] = 1'b0; // R11 R17
            end
          end
        endcase
        d.sack = take;
        if (!take) begin
          d.snext = SL_IDLE;
        end
      end else if (q.sst == SL_TX && q.scnt == 4'd8) begin
        d.stat[S_TXFULL] = 1'b0;
        d.stat[S_DATA] = 1'b1;
        d.sack = !sda_f;
        d.snext = sda_f ? SL_IDLE : SL_TX;
      end
    end else if (q.sst != SL_IDLE && scl_fall && q.scnt == 4'd9) begin
      d.scnt = 4'd0;
      d.sack = 1'b0;
      d.sst = q.snext;
      if (q.snext == SL_TX) begin
        d.ctrl[C_REL] = 1'b0; // R11 R12
      end
    end else if (q.sst != SL_IDLE && scl_fall && q.scnt == 4'd8 &&
                 !q.sack) begin
      d.sst = SL_IDLE;
    end
    // Data only moves while the clock is low, so no false start or stop.
    if (!scl_f) begin
      if (q.sst == SL_TX) begin
        d.sdrv = q.scnt < 4'd8 && !q.txd[~q.scnt[2:0]];
      end else begin
        d.sdrv = q.scnt == 4'd8 && q.sack;
      end
    end
    d.shold = q.sst != SL_IDLE && !scl_f && !q.ctrl[C_REL]; // R10

    // -------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------
    if (setup) begin
      unique case (PADDR_I)
        OFF_CTRL: d.prdata = {16'h0000, q.ctrl};
        OFF_STAT: d.prdata = {16'h0000, q.stat};
        OFF_BAUD: d.prdata = 32'(q.baud);
        OFF_MASK: d.prdata = {22'h000000, q.mask};
        OFF_OWN: d.prdata = {22'h000000, q.own};
        OFF_TX: d.prdata = {24'h000000, q.txd};
        OFF_RX: d.prdata = {24'h000000, q.rxd};
        default: d.prdata = 32'h00000000;
      endcase
    end
    // Reading the receive data empties it unless a byte lands now.
    if (rd && PADDR_I == OFF_RX && !landed) begin
      d.stat[S_RXFULL] = 1'b0;
    end
    if (wr) begin
      unique case (PADDR_I)
        OFF_CTRL: begin
          d.ctrl = PWDATA_I[15:0] & CTRL_WMASK; // R15
          if (!q.ctrl[C_STR]) begin
            d.ctrl[C_REL] = d.ctrl[C_REL] | q.ctrl[C_REL]; // R12
          end
        end
        OFF_BAUD: d.baud = PWDATA_I[BRG_W-1:0];
        OFF_MASK: d.mask = PWDATA_I[9:0];
        OFF_OWN: d.own = PWDATA_I[9:0];
        OFF_TX: begin
          d.txd = PWDATA_I[7:0];
          d.stat[S_TXFULL] = 1'b1;
        end
        default: ;
      endcase
    end

    if (!run) begin
      d.mst = M_IDLE;
      d.mscl = 1'b0;
      d.msda = 1'b0;
      d.mown = 1'b0;
      d.sst = SL_IDLE;
      d.sdrv = 1'b0;
      d.shold = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;
  assign PRDATA_O = q.prdata;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_O = q.ctrl[C_ON] && (q.mscl || q.shold); // R8 R10
  assign SDA_OE_O = q.ctrl[C_ON] && (q.msda || q.sdrv); // R8
  assign PIN_OWN_O = q.ctrl[C_ON]; // R8
  assign SLEW_OFF_O = q.ctrl[C_SLEW]; // R15
  assign SMB_LVL_O = q.ctrl[C_SMB]; // R15
  assign GC_EVT_O = q.gc_evt; // R16

endmodule

`default_nettype wire

// *** tw_ctrl_properties.sv ***
/*
  Port checker for the two-wire controller.
  Assumes it is bound to tw_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module tw_ctrl_properties
  import tw_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Pins and system
  input wire logic SCL_OE_O,
  input wire logic SDA_OE_O,
  input wire logic PIN_OWN_O,
  input wire logic SLEW_OFF_O,
  input wire logic SMB_LVL_O,
  input wire logic GC_EVT_O
);
  import tw_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic wr_c;
  logic bad_a;
  assign wr_c = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFF_CTRL;
  assign bad_a = PSEL_I && PADDR_I == 8'h1C;

  a_ready_high: assert property (PREADY_O)
    else $error("ready dropped");
  a_bad_addr: assert property (bad_a && PENABLE_I |-> PSLVERR_O)
    else $error("no slave error");
  a_rd_unmapped: assert property (bad_a && !PENABLE_I && !PWRITE_I
    |=> PRDATA_O == 32'h0) else $error("unmapped read not zero");
  a_pins_free: assert property (!PIN_OWN_O |-> !SCL_OE_O && !SDA_OE_O)
    else $error("pins driven while off");
  a_own_tracks: assert property (wr_c |=> PIN_OWN_O == $past(PWDATA_I[C_ON]))
    else $error("pin ownership wrong");
  a_slew_tracks: assert property (wr_c |=> SLEW_OFF_O == $past(PWDATA_I[C_SLEW]))
    else $error("slew output wrong");
  a_smb_tracks: assert property (wr_c |=> SMB_LVL_O == $past(PWDATA_I[C_SMB]))
    else $error("threshold output wrong");
  a_gc_pulse: assert property (GC_EVT_O |=> !GC_EVT_O)
    else $error("call event too long");

  cover property (GC_EVT_O);
  cover property (SDA_OE_O && SCL_OE_O);
  cover property (PSLVERR_O);
endmodule

bind tw_ctrl tw_ctrl_properties u_props (.CLK_I, .NRST_I, .PSEL_I,
  .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O,
  .PSLVERR_O, .SCL_OE_O, .SDA_OE_O, .PIN_OWN_O, .SLEW_OFF_O, .SMB_LVL_O,
  .GC_EVT_O);

`default_nettype wire

// *** tw_pkg.sv ***
/*
  Shared constants for the two-wire bus controller: register offsets,
  control and status bit positions, reset values, timing counts and
  the state encodings of the master and slave engines.
  Assumes a 25 MHz instruction clock and a 32-bit APB register bus.
*/
`default_nettype none

package tw_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned FCY_HZ = 25_000_000;
  // Fixed pin delay added to every bit period, in cycles.
  localparam int unsigned PIN_DLY_DIV_HZ = 10_000_000;
  localparam int unsigned PIN_DLY_CYC = FCY_HZ / PIN_DLY_DIV_HZ;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_OWN = 8'h10;
  localparam logic [7:0] OFF_TX = 8'h14;
  localparam logic [7:0] OFF_RX = 8'h18;

  // ---------------------------------------------------------------
  // bus_control fields
  // ---------------------------------------------------------------
  localparam int unsigned C_ON = 15;
  localparam int unsigned C_HALT = 13;
  localparam int unsigned C_REL = 12;
  localparam int unsigned C_ALL = 11;
  localparam int unsigned C_WIDE = 10;
  localparam int unsigned C_SLEW = 9;
  localparam int unsigned C_SMB = 8;
  localparam int unsigned C_GC = 7;
  localparam int unsigned C_STR = 6;
  localparam int unsigned C_ACKV = 5;
  localparam int unsigned C_ACKGO = 4;
  localparam int unsigned C_RXGO = 3;
  localparam int unsigned C_STOP = 2;
  localparam int unsigned C_RS = 1;
  localparam int unsigned C_START = 0;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] CTRL_WMASK = 16'hBFFF;

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam int unsigned S_ACKST = 15;
  localparam int unsigned S_TRST = 14;
  localparam int unsigned S_GCST = 9;
  localparam int unsigned S_ADD10 = 8;
  localparam int unsigned S_DATA = 5;
  localparam int unsigned S_STOPD = 4;
  localparam int unsigned S_STARTD = 3;
  localparam int unsigned S_RDIR = 2;
  localparam int unsigned S_RXFULL = 1;
  localparam int unsigned S_TXFULL = 0;

  // ---------------------------------------------------------------
  // Engine states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_RSTART = 3'b010,
    M_STOP = 3'b011,
    M_TX = 3'b100,
    M_RX = 3'b101,
    M_ACK = 3'b110
  } tw_mst_e;

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_ADDR2 = 3'b010,
    SL_RX = 3'b011,
    SL_TX = 3'b100
  } tw_slv_e;

endpackage

`default_nettype wire

// *** tw_sync.sv ***
/*
  Three-stage input synchroniser with agreement filter for pin inputs.
  Assumes idle-high open-drain lines, so the filtered value resets high.
*/
`timescale 1ns/1ps
`default_nettype none

module tw_sync #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Pins and filtered result
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } tw_sync_s;

  tw_sync_s q, d;

  // A change counts only once stages two and three agree.
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.f[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign lvl_o = q.f;

endmodule

`default_nettype wire
